// ### bench/eai_host.sv
`timescale 1ns/1ps
module eai_host (
    // clock
    input  wire logic       clk_sys,
    // microport
    output logic      [4:0] cpu_page,
    output logic      [4:0] cpu_addr,
    output logic      [7:0] cpu_wdata,
    output logic            cpu_wr,
    output logic            cpu_rd,
    input  wire logic [7:0] cpu_rdata,
    // request line
    input  wire logic       irq_n_o,
    input  wire logic       irq_n_oe,
    output logic            irq_n
);
    // board pull-up: a released request line reads high
    assign irq_n = irq_n_oe ? irq_n_o : 1'b1;

    initial begin
        cpu_page  = 5'h00;
        cpu_addr  = 5'h00;
        cpu_wdata = 8'h00;
        cpu_wr    = 1'b0;
        cpu_rd    = 1'b0;
    end

    // idle bus shows the inverse so stale values never look valid
    task automatic wr(input logic [4:0] pg, ad, input logic [7:0] dat);
        @(posedge clk_sys);
        cpu_page  <= pg;
        cpu_addr  <= ad;
        cpu_wdata <= dat;
        cpu_wr    <= 1'b1;
        @(posedge clk_sys);
        cpu_wr    <= 1'b0;
        cpu_wdata <= ~dat;
    endtask : wr

    task automatic rd(input logic [4:0] pg, ad, output logic [7:0] dat);
        @(posedge clk_sys);
        cpu_page <= pg;
        cpu_addr <= ad;
        cpu_rd   <= 1'b1;
        @(posedge clk_sys);
        cpu_rd   <= 1'b0;
        cpu_addr <= ~ad;
        #1;
        dat = cpu_rdata;
    endtask : rd
endmodule : eai_host

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic [4:0]  cpu_page, cpu_addr;
    logic [7:0]  cpu_wdata, cpu_rdata, category_vector, d;
    logic        cpu_wr, cpu_rd, irq_n_o, irq_n_oe, irq_n, tx_y_bit;
    logic        rx_bit_en = 1'b0, rx_bit = 1'b0, rx_ts16 = 1'b0;
    logic        rx_y_en = 1'b0, rx_y_bit = 1'b0;
    logic        mf_align_lost_status = 1'b0, tx_all_ones_pin_n = 1'b1;
    logic        rx_sync_lost = 1'b0;
    logic [38:0] ev = '0;
    logic [7:0]  ictl = 8'h00;
    int          n_fail = 0;
    int          total_checks = 0;
    // event bit index beside the category it should raise
    logic [15:0] rows [18] = '{16'h2680, 16'h2540, 16'h2420, 16'h2310,
        16'h2204, 16'h2120, 16'h1A01, 16'h1910, 16'h1708, 16'h1504,
        16'h1310, 16'h1280, 16'h1180, 16'h1008, 16'h0F02, 16'h0902,
        16'h0802, 16'h0001};

    always #50 clk_sys = ~clk_sys;

    eai_unit #(.ABN_CYCLES(40), .NRM_CYCLES(20)) uut (
        .clk_sys(clk_sys), .resetn(resetn), .cpu_page(cpu_page),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .rx_bit_en(rx_bit_en),
        .rx_bit(rx_bit), .rx_ts16(rx_ts16), .rx_y_en(rx_y_en),
        .rx_y_bit(rx_y_bit), .rx_sync_lost(rx_sync_lost),
        .mf_align_lost_status(mf_align_lost_status),
        .tx_all_ones_pin_n(tx_all_ones_pin_n), .ev_w0_hi(ev[38:37]),
        .ev_w0_lo(ev[36:34]), .ev_w1(ev[33:26]), .ev_w2_hi(ev[25:20]),
        .ev_w2_lo(ev[19]), .ev_w3_hi(ev[18:17]), .ev_sec(ev[16]),
        .ev_nat(ev[15:9]), .ev_link(ev[8:1]), .ev_link1(ev[0]),
        .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .tx_y_bit(tx_y_bit),
        .category_vector(category_vector));

    eai_host host (
        .clk_sys(clk_sys), .cpu_page(cpu_page), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
        .irq_n(irq_n));

    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic rc(input logic [4:0] pg, ad, input logic [7:0] m, e);
        host.rd(pg, ad, d);
        chk(d & m, e);
    endtask : rc

    task automatic pulse(input logic [7:0] b);
        @(posedge clk_sys);
        ev <= 39'd1 << b;
        @(posedge clk_sys);
        ev <= '0;
        #1;
    endtask : pulse

    // check pending vector and pin, then clear by read or acknowledge
    task automatic vec(input logic [7:0] e, input logic ack);
        chk(category_vector, e);
        chk({7'h00, irq_n}, {7'h00, e == 8'h00});
        if (ack) begin
            ictl = ictl ^ 8'h20;
            host.wr(eai_pkg::PG_CTRL, eai_pkg::A_ICTL, ictl);
            @(posedge clk_sys);
            #1;
        end else begin
            host.rd(eai_pkg::PG_CNT, eai_pkg::A_VEC, d);
            chk(d, e);
        end
        chk(category_vector, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
    endtask : vec

    task automatic bits(input int n, input int k);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            rx_bit_en <= 1'b1;
            rx_bit <= k == 1 || (k == 2 && i % 2 == 0)
                   || (k == 3 && i % 4 == 0);
            rx_ts16 <= i % 256 >= 128 && i % 256 < 136;
        end
        @(posedge clk_sys);
        rx_bit_en <= 1'b0;
    endtask : bits

    task automatic ychk(input logic s, input logic [7:0] e);
        @(posedge clk_sys);
        mf_align_lost_status <= s;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({7'h00, tx_y_bit}, e);
    endtask : ychk

    task automatic ypulse(input logic y);
        @(posedge clk_sys);
        rx_y_en <= 1'b1;
        rx_y_bit <= y;
        @(posedge clk_sys);
        rx_y_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : ypulse

    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        // let the normal timer settle while its interrupt is still masked
        repeat (30) @(posedge clk_sys);
        rc(eai_pkg::PG_CTRL, eai_pkg::A_MASK0, 8'hFF, 8'hFF);
        rc(eai_pkg::PG_CTRL, eai_pkg::A_MASK1, 8'hFF, 8'h00);
        pulse(8'h1A);
        vec(8'h00, 1'b0);
        host.wr(eai_pkg::PG_CTRL, eai_pkg::A_MASK1, 8'hFF);
        host.wr(eai_pkg::PG_CTRL, eai_pkg::A_MASK2, 8'hFF);
        host.wr(eai_pkg::PG_CTRL, eai_pkg::A_MASK3, 8'hFF);
        host.wr(eai_pkg::PG_CTRL, eai_pkg::A_NMASK, 8'hFF);
        host.wr(eai_pkg::PG_LINK, eai_pkg::A_LMASK, 8'hFF);
        for (int r = 0; r < 18; r++) begin
            pulse(rows[r][15:8]);
            vec(rows[r][7:0], r[0]);
        end
        pulse(8'h26);
        pulse(8'h00);
        vec(8'h81, 1'b0);
        host.wr(eai_pkg::PG_CTRL, eai_pkg::A_ICTL, ictl | 8'h40);
        pulse(8'h25);
        vec(8'h00, 1'b0);
        host.wr(eai_pkg::PG_CTRL, eai_pkg::A_ICTL, ictl);
        @(posedge clk_sys);
        tx_all_ones_pin_n <= 1'b0;
        pulse(8'h25);
        vec(8'h00, 1'b0);
        tx_all_ones_pin_n <= 1'b1;
        ychk(1'b1, 8'h01);
        ychk(1'b0, 8'h00);
        host.wr(eai_pkg::PG_CTRL, eai_pkg::A_MODE, 8'h08);
        host.wr(eai_pkg::PG_CTRL, eai_pkg::A_TXMF, 8'h04);
        ychk(1'b0, 8'h01);
        host.wr(eai_pkg::PG_CTRL, eai_pkg::A_TXMF, 8'h00);
        ychk(1'b1, 8'h00);
        ypulse(1'b1);
        vec(8'h80, 1'b0);
        rc(eai_pkg::PG_CNT, eai_pkg::A_LATCH, 8'h01, 8'h01);
        ypulse(1'b0);
        rc(eai_pkg::PG_CNT, eai_pkg::A_LATCH, 8'h01, 8'h01);
        rc(eai_pkg::PG_CNT, eai_pkg::A_LATCH, 8'h01, 8'h00);
        // 255 zeros must not yet count as signal loss
        bits(255, 0);
        rc(eai_pkg::PG_CNT, eai_pkg::A_LATCH, 8'h04, 8'h00);
        bits(1, 0);
        repeat (50) @(posedge clk_sys);
        #1;
        vec(8'h48, 1'b0);
        rc(eai_pkg::PG_STAT, eai_pkg::A_TSTAT, 8'h03, 8'h02);
        rc(eai_pkg::PG_CNT, eai_pkg::A_LATCH, 8'h04, 8'h04);
        bits(255, 3);
        repeat (30) @(posedge clk_sys);
        #1;
        vec(8'h08, 1'b0);
        rc(eai_pkg::PG_STAT, eai_pkg::A_TSTAT, 8'h03, 8'h01);
        rc(eai_pkg::PG_CNT, eai_pkg::A_LATCH, 8'h04, 8'h04);
        rc(eai_pkg::PG_CNT, eai_pkg::A_LATCH, 8'h04, 8'h00);
        bits(1100, 1);
        vec(8'h48, 1'b0);
        rc(eai_pkg::PG_CNT, eai_pkg::A_LATCH, 8'h18, 8'h18);
        bits(600, 2);
        rc(eai_pkg::PG_CNT, eai_pkg::A_LATCH, 8'h02, 8'h02);
        host.wr(eai_pkg::PG_CTRL, eai_pkg::A_MODE, 8'h20);
        @(posedge clk_sys);
        rc(eai_pkg::PG_CTRL, eai_pkg::A_MODE, 8'hFF, 8'h00);
        rc(eai_pkg::PG_CTRL, eai_pkg::A_MASK1, 8'hFF, 8'h00);
        rc(eai_pkg::PG_CTRL, eai_pkg::A_MASK0, 8'hFF, 8'hFF);
        // frame sync loss alone must count as abnormal signal
        @(posedge clk_sys);
        rx_sync_lost <= 1'b1;
        repeat (50) @(posedge clk_sys);
        rc(eai_pkg::PG_STAT, eai_pkg::A_TSTAT, 8'h03, 8'h02);
        rx_sync_lost <= 1'b0;
        repeat (30) @(posedge clk_sys);
        rc(eai_pkg::PG_STAT, eai_pkg::A_TSTAT, 8'h03, 8'h01);
        chk(category_vector, 8'h00);
        end_sim();
    end
endmodule : testbench

// ### rtl/eai_pkg.sv
package eai_pkg;
    // clock and timing
    localparam int CLK_KHZ      = 10000;
    localparam int ABN_TIME_MS  = 100;
    localparam int NRM_TIME_MS  = 10;
    // line detectors
    localparam int DFR_BITS     = 512;
    localparam int AIS_ZEROS    = 3;
    localparam int AUX_BITS     = 512;
    localparam int LOS_ZEROS    = 255;
    localparam int LOS_WIN      = 255;
    localparam int LOS_ONES     = 32;
    // register pages
    localparam logic [4:0] PG_CTRL = 5'h01;
    localparam logic [4:0] PG_STAT = 5'h03;
    localparam logic [4:0] PG_CNT  = 5'h04;
    localparam logic [4:0] PG_LINK = 5'h0B;
    // register offsets
    localparam logic [4:0] A_SEL   = 5'h10;
    localparam logic [4:0] A_MODE  = 5'h11;
    localparam logic [4:0] A_VEC   = 5'h12;
    localparam logic [4:0] A_TXMF  = 5'h13;
    localparam logic [4:0] A_LMASK = 5'h16;
    localparam logic [4:0] A_NMASK = 5'h19;
    localparam logic [4:0] A_ICTL  = 5'h1A;
    localparam logic [4:0] A_MASK0 = 5'h1B;
    localparam logic [4:0] A_MASK1 = 5'h1C;
    localparam logic [4:0] A_MASK2 = 5'h1D;
    localparam logic [4:0] A_MASK3 = 5'h1E;
    localparam logic [4:0] A_LATCH = 5'h1B;
    localparam logic [4:0] A_TSTAT = 5'h12;
    // field positions
    localparam int B_ALL_ONES_CRITERION_SELECT = 7;
    localparam int B_SRST = 5;
    localparam int B_AUTO_REMOTE_MF_ALARM_CTRL = 3;
    localparam int B_IRQ_SUSPEND = 6;
    localparam int B_IRQ_ACKNOWLEDGE_TOGGLE = 5;
    localparam int B_TXY  = 2;
    // reset values
    localparam logic [7:0] R_MASK0 = 8'hFF;
    localparam logic [7:0] R_MASK  = 8'h00;
    localparam logic [7:0] R_CTL   = 8'h00;
endpackage : eai_pkg

// ### rtl/eai_unit.sv
`timescale 1ns/1ps
// Operation
// - all-ones alarm: under three zeros, selectable windows
// - channel 16 all-ones reported as separate alarm
// - alternating pattern for 512 bits raises alarm
// - over 255 consecutive zeros enters signal loss
// - signal loss ends on 12.5 percent density window
// - remote multiframe alarm follows received Y-bit
// - abnormal timer bit after 100 ms abnormal
// - normal timer bit after 10 ms normal
// - alarm latch bits hold until register read
// - auto mode sends Y-bit while alignment lost
// - manual mode sends programmed Y-bit
// - unmasked event pulls request low, sets category
// - vector read clears vector, releases request
// - acknowledge bit toggle clears like vector read
// - categories one-hot, synchronization in bit seven
// - sync and alarm events map to categories
// - counter, second, slip, signalling events mapped
// - reset masks all words except word zero
// - suspend bit withholds all interrupts
// - transmit all-ones pin low suspends interrupts
// - soft reset bit rising restores defaults
// - mask bit one unmasks; national category sources
module eai_unit #(
    parameter int ABN_CYCLES = eai_pkg::ABN_TIME_MS * eai_pkg::CLK_KHZ,
    parameter int NRM_CYCLES = eai_pkg::NRM_TIME_MS * eai_pkg::CLK_KHZ
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // microport
    input  wire logic [4:0] cpu_page,
    input  wire logic [4:0] cpu_addr,
    input  wire logic [7:0] cpu_wdata,
    input  wire logic       cpu_wr,
    input  wire logic       cpu_rd,
    output logic      [7:0] cpu_rdata,
    // receive line
    input  wire logic       rx_bit_en,
    input  wire logic       rx_bit,
    input  wire logic       rx_ts16,
    input  wire logic       rx_y_en,
    input  wire logic       rx_y_bit,
    input  wire logic       rx_sync_lost,
    input  wire logic       mf_align_lost_status,
    input  wire logic       tx_all_ones_pin_n,
    // event pulses from the framer
    input  wire logic [1:0] ev_w0_hi,
    input  wire logic [2:0] ev_w0_lo,
    input  wire logic [7:0] ev_w1,
    input  wire logic [5:0] ev_w2_hi,
    input  wire logic       ev_w2_lo,
    input  wire logic [1:0] ev_w3_hi,
    input  wire logic       ev_sec,
    input  wire logic [6:0] ev_nat,
    input  wire logic [7:0] ev_link,
    input  wire logic       ev_link1,
    // outputs
    output logic            irq_n_o,
    output logic            irq_n_oe,
    output logic            tx_y_bit,
    output logic      [7:0] category_vector
);
    localparam int T1W = $clog2(ABN_CYCLES + 1);
    localparam int T2W = $clog2(NRM_CYCLES + 1);

    logic [7:0] sel_reg, mode_reg, txmf_reg, lmask_reg, nmask_reg;
    logic [7:0] ictl_reg, mask0_reg, mask1_reg, mask2_reg, mask3_reg;
    logic [7:0] vec_reg, vec_next, rdata_reg;
    logic [4:0] latch_reg, latch_next, alm_d_reg;
    logic       srst_reg, irq_reg, txy_reg;

    // decode
    wire pg1 = cpu_page == eai_pkg::PG_CTRL;
    wire pg3 = cpu_page == eai_pkg::PG_STAT;
    wire pg4 = cpu_page == eai_pkg::PG_CNT;
    wire pgl = cpu_page == eai_pkg::PG_LINK;
    wire we1 = cpu_wr & pg1;
    wire we_sel   = we1 & (cpu_addr == eai_pkg::A_SEL);
    wire we_mode  = we1 & (cpu_addr == eai_pkg::A_MODE);
    wire we_txmf  = we1 & (cpu_addr == eai_pkg::A_TXMF);
    wire we_nmask = we1 & (cpu_addr == eai_pkg::A_NMASK);
    wire we_ictl  = we1 & (cpu_addr == eai_pkg::A_ICTL);
    wire we_mask0 = we1 & (cpu_addr == eai_pkg::A_MASK0);
    wire we_mask1 = we1 & (cpu_addr == eai_pkg::A_MASK1);
    wire we_mask2 = we1 & (cpu_addr == eai_pkg::A_MASK2);
    wire we_mask3 = we1 & (cpu_addr == eai_pkg::A_MASK3);
    wire we_lmask = cpu_wr & pgl & (cpu_addr == eai_pkg::A_LMASK);
    wire rd_vec   = cpu_rd & pg4 & (cpu_addr == eai_pkg::A_VEC);
    wire rd_latch = cpu_rd & pg4 & (cpu_addr == eai_pkg::A_LATCH);
    wire rd_tstat = cpu_rd & pg3 & (cpu_addr == eai_pkg::A_TSTAT);

    wire all_ones_criterion_select = sel_reg[eai_pkg::B_ALL_ONES_CRITERION_SELECT];
    wire auto_remote_mf_alarm_ctrl = mode_reg[eai_pkg::B_AUTO_REMOTE_MF_ALARM_CTRL];
    // only a 0 to 1 change of the soft-reset bit counts
    wire srst_req = we_mode & cpu_wdata[eai_pkg::B_SRST]
                  & ~mode_reg[eai_pkg::B_SRST];
    wire ack_tog = we_ictl & (cpu_wdata[eai_pkg::B_IRQ_ACKNOWLEDGE_TOGGLE]
                  != ictl_reg[eai_pkg::B_IRQ_ACKNOWLEDGE_TOGGLE]);
    wire suspend = ictl_reg[eai_pkg::B_IRQ_SUSPEND]
                 | ~tx_all_ones_pin_n;

    // soft reset lasts one cycle after the write
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            srst_reg <= 1'b0;
        else
            srst_reg <= srst_req;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sel_reg   <= eai_pkg::R_CTL;
            mode_reg  <= eai_pkg::R_CTL;
            txmf_reg  <= eai_pkg::R_CTL;
            ictl_reg  <= eai_pkg::R_CTL;
            mask0_reg <= eai_pkg::R_MASK0;
            mask1_reg <= eai_pkg::R_MASK;
            mask2_reg <= eai_pkg::R_MASK;
            mask3_reg <= eai_pkg::R_MASK;
            nmask_reg <= eai_pkg::R_MASK;
            lmask_reg <= eai_pkg::R_MASK;
        end else if (srst_reg) begin
            sel_reg   <= eai_pkg::R_CTL;
            mode_reg  <= eai_pkg::R_CTL;
            txmf_reg  <= eai_pkg::R_CTL;
            ictl_reg  <= eai_pkg::R_CTL;
            mask0_reg <= eai_pkg::R_MASK0;
            mask1_reg <= eai_pkg::R_MASK;
            mask2_reg <= eai_pkg::R_MASK;
            mask3_reg <= eai_pkg::R_MASK;
            nmask_reg <= eai_pkg::R_MASK;
            lmask_reg <= eai_pkg::R_MASK;
        end else begin
            if (we_sel)   sel_reg   <= cpu_wdata;
            if (we_mode)  mode_reg  <= cpu_wdata;
            if (we_txmf)  txmf_reg  <= cpu_wdata;
            if (we_ictl)  ictl_reg  <= cpu_wdata;
            if (we_mask0) mask0_reg <= cpu_wdata;
            if (we_mask1) mask1_reg <= cpu_wdata;
            if (we_mask2) mask2_reg <= cpu_wdata;
            if (we_mask3) mask3_reg <= cpu_wdata;
            if (we_nmask) nmask_reg <= cpu_wdata;
            if (we_lmask) lmask_reg <= cpu_wdata;
        end
    end

    // double-frame windows for the all-ones detectors
    logic [8:0] dfr_cnt;
    logic [1:0] zc_reg;
    logic       few_d_reg, ais_reg, t16z_reg, ts16_reg;
    wire dfr_end = rx_bit_en & (dfr_cnt == 9'(eai_pkg::DFR_BITS - 1));
    wire [1:0] zc_inc = (!rx_bit && zc_reg != 2'h3) ? zc_reg + 2'h1
                                                     : zc_reg;
    wire few_now = zc_inc < 2'(eai_pkg::AIS_ZEROS);
    wire t16z_now = t16z_reg | (rx_ts16 & ~rx_bit);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dfr_cnt   <= 9'h000;
            zc_reg    <= 2'h0;
            few_d_reg <= 1'b0;
            ais_reg   <= 1'b0;
            t16z_reg  <= 1'b0;
            ts16_reg  <= 1'b0;
        end else if (dfr_end) begin
            dfr_cnt   <= 9'h000;
            zc_reg    <= 2'h0;
            t16z_reg  <= 1'b0;
            few_d_reg <= few_now;
            ais_reg   <= all_ones_criterion_select ? (few_now & few_d_reg) : few_now;
            ts16_reg  <= ~t16z_now;
        end else if (rx_bit_en) begin
            dfr_cnt   <= dfr_cnt + 9'h001;
            zc_reg    <= zc_inc;
            t16z_reg  <= t16z_now;
        end
    end

    // alternating pattern: 512 bits means 511 transitions in a row
    logic [9:0] aux_cnt;
    logic       rx_prev, aux_reg;
    wire [9:0] aux_full = 10'(eai_pkg::AUX_BITS - 1);
    wire [9:0] aux_next = (rx_bit == rx_prev) ? 10'h000
                        : (aux_cnt == aux_full) ? aux_cnt
                        : aux_cnt + 10'h001;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aux_cnt <= 10'h000;
            rx_prev <= 1'b0;
            aux_reg <= 1'b0;
        end else if (rx_bit_en) begin
            rx_prev <= rx_bit;
            aux_cnt <= aux_next;
            aux_reg <= aux_next == aux_full;
        end
    end

    // loss of signal; the exit window restarts at the next pulse
    logic [8:0] zrun;
    logic [7:0] win_pos, win_ones;
    logic       win_on, los_reg;
    wire [8:0] zrun_next = rx_bit ? 9'h000
                         : (zrun[8] ? zrun : zrun + 9'h001);
    wire [7:0] ones_next = win_ones + {7'h00, rx_bit};
    wire       win_last  = win_pos == 8'(eai_pkg::LOS_WIN - 1);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            zrun     <= 9'h000;
            win_pos  <= 8'h00;
            win_ones <= 8'h00;
            win_on   <= 1'b0;
            los_reg  <= 1'b0;
        end else if (rx_bit_en) begin
            zrun <= zrun_next;
            if (zrun_next > 9'(eai_pkg::LOS_ZEROS)) begin
                los_reg <= 1'b1;
                win_on  <= 1'b0;
            end else if (los_reg && !win_on && rx_bit) begin
                win_on   <= 1'b1;
                win_pos  <= 8'h01;
                win_ones <= 8'h01;
            end else if (win_on) begin
                win_pos  <= win_pos + 8'h01;
                win_ones <= ones_next;
                if (win_last) begin
                    win_on <= 1'b0;
                    if (ones_next >= 8'(eai_pkg::LOS_ONES))
                        los_reg <= 1'b0;
                end
            end
        end
    end

    // remote multiframe alarm and the abnormal/normal timers
    logic           ymf_reg, t1_reg, t2_reg;
    logic [T1W-1:0] t1_cnt;
    logic [T2W-1:0] t2_cnt;
    wire abnormal = los_reg | ais_reg | rx_sync_lost;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            ymf_reg <= 1'b0;
        else if (rx_y_en)
            ymf_reg <= rx_y_bit;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            t1_cnt <= '0;
            t1_reg <= 1'b0;
        end else if (!abnormal) begin
            t1_cnt <= '0;
            t1_reg <= 1'b0;
        end else if (t1_cnt == T1W'(ABN_CYCLES - 1)) begin
            t1_reg <= 1'b1;
        end else begin
            t1_cnt <= t1_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            t2_cnt <= '0;
            t2_reg <= 1'b0;
        end else if (abnormal) begin
            t2_cnt <= '0;
            t2_reg <= 1'b0;
        end else if (t2_cnt == T2W'(NRM_CYCLES - 1)) begin
            t2_reg <= 1'b1;
        end else begin
            t2_cnt <= t2_cnt + 1'b1;
        end
    end

    // alarm edges become events; levels feed the read latch
    logic t1_d_reg, t2_d_reg;
    wire [4:0] alm = {ais_reg, ts16_reg, los_reg, aux_reg, ymf_reg};
    wire [4:0] rise = alm & ~alm_d_reg;
    wire t1_ev = t1_reg & ~t1_d_reg;
    wire t2_ev = t2_reg & ~t2_d_reg;

    // mask words: a one unmasks the source
    wire [7:0] w0 = {ev_w0_hi, rise[4], rise[3], rise[2], ev_w0_lo};
    wire [7:0] w2 = {ev_w2_hi, rise[1], ev_w2_lo};
    wire [7:0] w3 = {ev_w3_hi, rise[0], ev_sec, t1_ev, t2_ev, 2'b00};
    wire [7:0] u0 = w0 & mask0_reg;
    wire [7:0] u1 = ev_w1 & mask1_reg;
    wire [7:0] u2 = w2 & mask2_reg;
    wire [7:0] u3 = w3 & mask3_reg;
    wire nat_hit = |(ev_nat & nmask_reg[6:0])
                 | |(ev_link & lmask_reg);

    wire [7:0] cat;
    assign cat[7] = u0[7] | u3[7] | u3[6] | u3[5];
    assign cat[6] = |u0[6:3] | u2[1];
    assign cat[5] = |u1[7:1] | u0[2];
    assign cat[4] = |u2[7:6] | u2[4] | u2[2] | u2[0] | u0[1];
    assign cat[3] = u3[4] | u2[5] | u3[3] | u3[2];
    assign cat[2] = u0[0] | u2[3];
    assign cat[1] = nat_hit;
    assign cat[0] = u1[0] | ev_link1;

    // a new event in the clearing cycle survives the clear
    wire vec_clr = rd_vec | ack_tog;
    assign vec_next = (vec_clr ? 8'h00 : vec_reg)
                    | (suspend ? 8'h00 : cat);
    assign latch_next = (rd_latch ? 5'h00 : latch_reg) | alm;

    wire [7:0] rd_val =
          (pg1 && cpu_addr == eai_pkg::A_SEL)   ? sel_reg
        : (pg1 && cpu_addr == eai_pkg::A_MODE)  ? mode_reg
        : (pg1 && cpu_addr == eai_pkg::A_TXMF)  ? txmf_reg
        : (pg1 && cpu_addr == eai_pkg::A_NMASK) ? nmask_reg
        : (pg1 && cpu_addr == eai_pkg::A_ICTL)  ? ictl_reg
        : (pg1 && cpu_addr == eai_pkg::A_MASK0) ? mask0_reg
        : (pg1 && cpu_addr == eai_pkg::A_MASK1) ? mask1_reg
        : (pg1 && cpu_addr == eai_pkg::A_MASK2) ? mask2_reg
        : (pg1 && cpu_addr == eai_pkg::A_MASK3) ? mask3_reg
        : (pgl && cpu_addr == eai_pkg::A_LMASK) ? lmask_reg
        : rd_vec   ? vec_reg
        : rd_latch ? {3'h0, latch_reg}
        : rd_tstat ? {6'h00, t1_reg, t2_reg}
        : 8'h00;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            vec_reg   <= 8'h00;
            latch_reg <= 5'h00;
            alm_d_reg <= 5'h00;
            t1_d_reg  <= 1'b0;
            t2_d_reg  <= 1'b0;
            irq_reg   <= 1'b0;
            txy_reg   <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            vec_reg   <= srst_reg ? 8'h00 : vec_next;
            latch_reg <= srst_reg ? 5'h00 : latch_next;
            alm_d_reg <= alm;
            t1_d_reg  <= t1_reg;
            t2_d_reg  <= t2_reg;
            irq_reg   <= ~srst_reg && vec_next != 8'h00;
            txy_reg   <= auto_remote_mf_alarm_ctrl ? txmf_reg[eai_pkg::B_TXY]
                              : mf_align_lost_status;
            if (cpu_rd)
                rdata_reg <= rd_val;
        end
    end

    assign cpu_rdata       = rdata_reg;
    assign category_vector = vec_reg;
    assign irq_n_o         = ~irq_reg;
    assign irq_n_oe        = irq_reg;
    assign tx_y_bit        = txy_reg;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_irq_tracks_vec:
    assert property (vec_reg != 8'h00 && !srst_reg |-> irq_n_oe
                     && !irq_n_o)
    else $error("request not driven while vector pending");
    a_vec_read_clear:
    assert property (rd_vec && (suspend || cat == 8'h00) && !srst_reg
                     |=> vec_reg == 8'h00 && !irq_n_oe)
    else $error("vector read did not clear vector");
    a_ack_clear:
    assert property (ack_tog && (suspend || cat == 8'h00)
                     |=> vec_reg == 8'h00)
    else $error("acknowledge toggle did not clear vector");
    a_suspend_holds:
    assert property (suspend && vec_reg == 8'h00 |=> vec_reg == 8'h00)
    else $error("vector set while suspended");
    a_soft_masks:
    assert property (srst_reg |=> mask0_reg == 8'hFF
                     && mask1_reg == 8'h00 && mask3_reg == 8'h00)
    else $error("mask defaults wrong after soft reset");
    a_los_entry:
    assert property (rx_bit_en && !rx_bit && zrun == 9'd255
                     |=> los_reg)
    else $error("signal loss not entered after 256 zeros");
    a_ais_single:
    assert property (dfr_end && !all_ones_criterion_select && few_now |=> ais_reg)
    else $error("all-ones alarm missed in single window");
    a_latch_sticky:
    assert property (latch_reg[2] && !rd_latch && !srst_reg
                     |=> latch_reg[2])
    else $error("alarm latch bit lost without read");
    a_timer_low:
    assert property (!abnormal |=> !t1_reg ##1 !t1_d_reg || abnormal)
    else $error("abnormal timer bit high during normal signal");
    a_tx_y_auto:
    assert property (!auto_remote_mf_alarm_ctrl && mf_align_lost_status |=> tx_y_bit)
    else $error("automatic Y-bit not sent");
    a_cat_alarm:
    assert property (rise[2] && mask0_reg[3] && !suspend && !srst_reg
                     |=> vec_reg[6])
    else $error("loss of signal did not set alarm category");
endmodule : eai_unit
